// >>> rfc_pkg.sv
// Purpose: shared constants and types of the rf configuration registers
// Assumes: byte-wide command link, address byte then payload msb first
// Notes:   all field positions and command lengths live here
//
// Overview of operation
// - gain tracking set recomputes amp and attenuators per frequency change
// - level fields latched only when the latch bit of the command is one
// - amp control bit zero keeps the amplifier untouched by the computation
// - two-bit field picks noise versus linearity trade-off, 0 noise, 3 linear
// - expected input level is 7-bit dB magnitude plus sign, one negative
// - expected mixer level is 7-bit dB magnitude plus sign, one negative
// - expected output level is 7-bit dB magnitude plus sign, one negative
// - store command saves all settings to nonvolatile memory for startup
// - standby bit one powers section down, zero returns it to active
// - section code 0 whole device, 1-3 oscillators, 4 signal chain
// - lock bit clear uses internal reference, set locks to external one
// - reference output enable bit turns the reference port on
// - backplane export bit works on one variant only, else no function
// - 16-bit trim word driven onto the internal oscillator tuning input
// - path bit zero feeds first mixer, one routes oscillator to port
// - one attenuator code step equals a quarter of a dB
package rfc_pkg;

  // ****************************************************************
  // register addresses and payload lengths
  // ****************************************************************
  localparam logic [7:0] ADDR_AUTO_GAIN  = 8'h17;
  localparam logic [7:0] ADDR_SAVE       = 8'h18;
  localparam logic [7:0] ADDR_STANDBY    = 8'h19;
  localparam logic [7:0] ADDR_REF_CLOCK  = 8'h1a;
  localparam logic [7:0] ADDR_REF_TRIM   = 8'h1b;
  localparam logic [7:0] ADDR_OSC_ROUTE  = 8'h1c;
  localparam logic [2:0] LEN_AUTO_GAIN   = 3'h5;
  localparam logic [2:0] LEN_REF_TRIM    = 3'h3;
  localparam logic [2:0] LEN_SHORT       = 3'h1;
  localparam int         PAYLOAD_W       = 40;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AG_TRACK_BIT = 0;
  localparam int AG_LATCH_BIT = 1;
  localparam int AG_AMP_BIT   = 2;
  localparam int AG_MODE_LSB  = 3;
  localparam int AG_IN_LSB    = 8;
  localparam int AG_MIX_LSB   = 16;
  localparam int AG_OUT_LSB   = 24;
  localparam int SB_STATE_BIT = 0;
  localparam int SB_SECT_LSB  = 1;
  localparam int RC_LOCK_BIT  = 0;
  localparam int RC_PORT_BIT  = 1;
  localparam int RC_RATE_BIT  = 2;
  localparam int RC_BPL_BIT   = 3;
  localparam int TRIM_LSB     = 0;
  localparam int ROUTE_BIT    = 0;
  localparam int QDB_SHIFT    = 2;

  // ****************************************************************
  // standby sections and answer codes
  // ****************************************************************
  localparam logic [2:0] SECT_DEVICE = 3'h0;
  localparam logic [2:0] SECT_CHAIN  = 3'h4;
  localparam int         SECT_N      = 5;
  localparam logic [7:0] ACK_OK      = 8'h00;
  localparam logic [7:0] ACK_UNKNOWN = 8'hff;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic       neg;
    logic [6:0] mag;
  } rfc_lvl_t;

  typedef struct packed {
    logic                gain_track_on;
    logic                amp_follow_computation;
    logic [1:0]          noise_linearity_tradeoff;
    rfc_lvl_t            expected_input_db;
    rfc_lvl_t            expected_mixer_db;
    rfc_lvl_t            expected_output_db;
    logic [SECT_N-1:0]   section_standby;
    logic                external_ref_lock;
    logic                ref_port_drive;
    logic                ref_out_rate_select;
    logic                backplane_clock_export;
    logic [15:0]         ref_trim_word;
    logic                first_osc_routing;
  } rfc_cfg_t;

  typedef struct packed {
    logic [7:0]           addr;
    logic [PAYLOAD_W-1:0] payload;
  } rfc_cmd_t;

  typedef struct packed {
    logic        valid;
    logic signed [10:0] gain_qdb;
    logic signed [10:0] mixer_qdb;
    logic        amp_allowed;
    logic [1:0]  tradeoff;
  } rfc_gain_req_t;

  localparam rfc_cfg_t CFG_RESET = '0;

  // payload bytes that follow an address byte
  function automatic logic [2:0] payload_len(input logic [7:0] addr);
    case (addr)
      ADDR_AUTO_GAIN: payload_len = LEN_AUTO_GAIN;
      ADDR_REF_TRIM:  payload_len = LEN_REF_TRIM;
      default:        payload_len = LEN_SHORT;
    endcase
  endfunction : payload_len

  // sign and magnitude in dB to signed quarter-dB steps
  function automatic logic signed [10:0] lvl_to_qdb(input rfc_lvl_t l);
    logic signed [10:0] v;
    v = signed'(11'(l.mag) << QDB_SHIFT);
    lvl_to_qdb = l.neg ? -v : v;
  endfunction : lvl_to_qdb

endpackage : rfc_pkg

// >>> rfc_cmd_rx.sv
// Purpose: splits the byte stream into address and payload
// Assumes: host waits for the answer byte before the next command
// Notes:   stalls on rx_ready until released
`timescale 1ns/1ns
module rfc_cmd_rx
  import rfc_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             open_i,
  input  wire logic             release_i,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_byte,
  output      logic             rx_ready,
  output      logic             cmd_valid,
  output      rfc_pkg::rfc_cmd_t cmd
);
  import rfc_pkg::*;

  typedef enum logic [1:0] {RX_ADDR, RX_DATA, RX_WAIT} rfc_rx_st_t;

  typedef struct packed {
    rfc_rx_st_t st;
    logic [2:0] left;
    logic       rdy;
    logic       done;
    rfc_cmd_t   cmd;
  } rfc_rx_t;

  rfc_rx_t q, d;
  logic    take;

  assign take = rx_valid & q.rdy;

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    case (q.st)
      RX_ADDR:
      begin
        if (take)
        begin
          d.cmd.addr    = rx_byte;
          d.cmd.payload = '0;
          d.left        = payload_len(rx_byte);
          d.st          = RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (take)
        begin
          d.cmd.payload = {q.cmd.payload[PAYLOAD_W-9:0], rx_byte};
          d.left        = q.left - 3'h1;
          if (q.left == LEN_SHORT)
          begin
            d.done = 1'b1;
            d.st   = RX_WAIT;
          end
        end
      end
      RX_WAIT:
      begin
        if (release_i)
          d.st = RX_ADDR;
      end
      default: d.st = RX_ADDR;
    endcase
    d.rdy = (d.st != RX_WAIT) & open_i;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign rx_ready  = q.rdy;
  assign cmd_valid = q.done;
  assign cmd       = q.cmd;

endmodule : rfc_cmd_rx

// >>> rfc_ack_tx.sv
// Purpose: holds the one answer byte until the host takes it
// Assumes: send only while no answer is pending
// Notes:   taken pulses one cycle after the host read
`timescale 1ns/1ns
module rfc_ack_tx
  import rfc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       send,
  input  wire logic [7:0] code,
  input  wire logic       tx_take,
  output      logic       tx_valid,
  output      logic [7:0] tx_byte,
  output      logic       taken
);
  import rfc_pkg::*;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       taken;
  } rfc_tx_t;

  rfc_tx_t q, d;

  always_comb
  begin
    d       = q;
    d.taken = 1'b0;
    if (q.valid & tx_take)
    begin
      d.valid = 1'b0;
      d.taken = 1'b1;
    end
    else if (send & ~q.valid)
    begin
      d.valid = 1'b1;
      d.data  = code;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign tx_valid = q.valid;
  assign tx_byte  = q.data;
  assign taken    = q.taken;

endmodule : rfc_ack_tx

// >>> rfc_regs.sv
// Purpose: command-addressed configuration registers of the downconverter
// Assumes: nonvolatile store answers save and load requests by handshake
// Notes:   settings load from the store after reset before commands open
`timescale 1ns/1ns
module rfc_regs
  import rfc_pkg::*;
#(
  parameter bit HAS_BACKPLANE_EXPORT = 1'b0
)
(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_byte,
  output      logic               rx_ready,
  output      logic               tx_valid,
  output      logic [7:0]         tx_byte,
  input  wire logic               tx_take,
  input  wire logic               freq_changed,
  output      rfc_pkg::rfc_gain_req_t gain_req,
  output      rfc_pkg::rfc_cfg_t  settings,
  output      logic               nv_save_req,
  output      logic               nv_load_req,
  input  wire logic               nv_save_done,
  input  wire logic               nv_load_valid,
  input  wire rfc_pkg::rfc_cfg_t  nv_load_cfg
);
  import rfc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_BOOT_REQ,
    ST_BOOT_WAIT,
    ST_RUN,
    ST_SAVE_WAIT,
    ST_ACK_WAIT
  } rfc_main_st_t;

  typedef struct packed {
    rfc_main_st_t  st;
    rfc_cfg_t      cfg;
    rfc_gain_req_t gain;
    logic          save_req;
    logic          load_req;
    logic          open;
    logic          send;
    logic [7:0]    code;
  } rfc_main_t;

  rfc_main_t q, d;

  // ****************************************************************
  // links to the framer and the answer holder
  // ****************************************************************
  logic     cmd_valid;
  rfc_cmd_t cmd;
  logic     ack_taken;

  rfc_cmd_rx u_rx (
    .mclk      (mclk),
    .rst       (rst),
    .open_i    (q.open),
    .release_i (ack_taken),
    .rx_valid  (rx_valid),
    .rx_byte   (rx_byte),
    .rx_ready  (rx_ready),
    .cmd_valid (cmd_valid),
    .cmd       (cmd)
  );

  rfc_ack_tx u_tx (
    .mclk     (mclk),
    .rst      (rst),
    .send     (q.send),
    .code     (q.code),
    .tx_take  (tx_take),
    .tx_valid (tx_valid),
    .tx_byte  (tx_byte),
    .taken    (ack_taken)
  );

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic [PAYLOAD_W-1:0] pl;
  logic [2:0]           sect;
  logic                 sb_state;

  assign pl       = cmd.payload;
  assign sect     = pl[SB_SECT_LSB +: 3];
  assign sb_state = pl[SB_STATE_BIT];

  // strip the export bit where the variant lacks it
  function automatic rfc_cfg_t variant_mask(input rfc_cfg_t c);
    rfc_cfg_t r;
    r = c;
    if (!HAS_BACKPLANE_EXPORT)
      r.backplane_clock_export = 1'b0;
    variant_mask = r;
  endfunction : variant_mask

  always_comb
  begin
    d          = q;
    d.save_req = 1'b0;
    d.load_req = 1'b0;
    d.send     = 1'b0;
    d.gain.valid = 1'b0;

    // gain recompute on each frequency step while gain tracking is on
    if (freq_changed & q.cfg.gain_track_on)
    begin
      d.gain.valid       = 1'b1;
      d.gain.gain_qdb    = lvl_to_qdb(q.cfg.expected_output_db)
                         - lvl_to_qdb(q.cfg.expected_input_db);
      d.gain.mixer_qdb   = lvl_to_qdb(q.cfg.expected_mixer_db)
                         - lvl_to_qdb(q.cfg.expected_input_db);
      d.gain.amp_allowed = q.cfg.amp_follow_computation;
      d.gain.tradeoff    = q.cfg.noise_linearity_tradeoff;
    end

    case (q.st)
      ST_BOOT_REQ:
      begin
        d.load_req = 1'b1;
        d.st       = ST_BOOT_WAIT;
      end

      ST_BOOT_WAIT:
      begin
        if (nv_load_valid)
        begin
          d.cfg  = variant_mask(nv_load_cfg);
          d.open = 1'b1;
          d.st   = ST_RUN;
        end
      end

      ST_RUN:
      begin
        if (cmd_valid)
        begin
          d.code = ACK_OK;
          d.send = 1'b1;
          d.st   = ST_ACK_WAIT;
          case (cmd.addr)
            ADDR_AUTO_GAIN:
            begin
              d.cfg.gain_track_on = pl[AG_TRACK_BIT];
              d.cfg.amp_follow_computation = pl[AG_AMP_BIT];
              d.cfg.noise_linearity_tradeoff =
                pl[AG_MODE_LSB +: 2];
              if (pl[AG_LATCH_BIT])
              begin
                d.cfg.expected_input_db  = pl[AG_IN_LSB +: 8];
                d.cfg.expected_mixer_db  = pl[AG_MIX_LSB +: 8];
                d.cfg.expected_output_db = pl[AG_OUT_LSB +: 8];
              end
            end

            ADDR_SAVE:
            begin
              d.save_req = 1'b1;
              d.send     = 1'b0;
              d.st       = ST_SAVE_WAIT;
            end

            ADDR_STANDBY:
            begin
              if (sect == SECT_DEVICE)
                d.cfg.section_standby = {SECT_N{sb_state}};
              else if (sect <= SECT_CHAIN)
                d.cfg.section_standby[sect] = sb_state;
            end

            ADDR_REF_CLOCK:
            begin
              d.cfg.external_ref_lock   = pl[RC_LOCK_BIT];
              d.cfg.ref_port_drive      = pl[RC_PORT_BIT];
              d.cfg.ref_out_rate_select = pl[RC_RATE_BIT];
              d.cfg.backplane_clock_export =
                HAS_BACKPLANE_EXPORT & pl[RC_BPL_BIT];
            end

            ADDR_REF_TRIM:
              d.cfg.ref_trim_word = pl[TRIM_LSB +: 16];

            ADDR_OSC_ROUTE:
              d.cfg.first_osc_routing = pl[ROUTE_BIT];

            default:
              d.code = ACK_UNKNOWN;
          endcase
        end
      end

      ST_SAVE_WAIT:
      begin
        if (nv_save_done)
        begin
          d.code = ACK_OK;
          d.send = 1'b1;
          d.st   = ST_ACK_WAIT;
        end
      end

      ST_ACK_WAIT:
      begin
        if (ack_taken)
          d.st = ST_RUN;
      end

      default: d.st = ST_BOOT_REQ;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q      <= '0;
      q.st   <= ST_BOOT_REQ;
      q.cfg  <= CFG_RESET;
    end
    else
      q <= d;
  end

  assign gain_req    = q.gain;
  assign settings    = q.cfg;
  assign nv_save_req = q.save_req;
  assign nv_load_req = q.load_req;

endmodule : rfc_regs

// >>> rfc_regs_sva.sv
// Purpose: port-level checks of the rf configuration registers
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to rfc_regs from the testbench top file
`timescale 1ns/1ns
module rfc_regs_sva
  import rfc_pkg::*;
#(
  parameter bit HAS_BACKPLANE_EXPORT = 1'b0
)
(
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   rx_valid,
  input wire logic [7:0]             rx_byte,
  input wire logic                   rx_ready,
  input wire logic                   tx_valid,
  input wire logic [7:0]             tx_byte,
  input wire logic                   tx_take,
  input wire logic                   freq_changed,
  input wire rfc_pkg::rfc_gain_req_t gain_req,
  input wire rfc_pkg::rfc_cfg_t      settings,
  input wire logic                   nv_save_req,
  input wire logic                   nv_load_req,
  input wire logic                   nv_save_done,
  input wire logic                   nv_load_valid,
  input wire rfc_pkg::rfc_cfg_t      nv_load_cfg
);
  import rfc_pkg::*;
  // ****************************************************************
  // answer handshake
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    tx_valid && tx_take;
  endsequence
  sequence s_reopen;
    !rx_ready ##1 rx_ready;
  endsequence
  a_answer_holds:
    assert property (tx_valid && !tx_take |=> tx_valid && $stable(tx_byte))
    else $error("answer byte dropped before it was read");
  a_answer_clears:
    assert property (s_take |=> !tx_valid)
    else $error("answer byte still pending after read");
  a_link_reopens:
    assert property (s_take |=> s_reopen)
    else $error("byte link did not reopen two edges after read");
  a_one_answer:
    assert property (tx_valid |-> !rx_ready)
    else $error("byte link open while answer pending");
  // ****************************************************************
  // configuration and side effects
  // ****************************************************************
  a_gain_on_step:
    assert property (freq_changed && settings.gain_track_on |=> gain_req.valid)
    else $error("no gain request after frequency step");
  a_gain_cause:
    assert property (gain_req.valid |->
      $past(freq_changed) && $past(settings.gain_track_on))
    else $error("gain request without tracking step");
  a_cfg_quiet:
    assert property (!$stable(settings) |-> !rx_ready)
    else $error("settings changed while command link open");
  a_save_pulse:
    assert property (nv_save_req |=> !nv_save_req)
    else $error("save request longer than one cycle");
  a_load_start:
    assert property ($fell(rst) |-> ##[0:2] nv_load_req)
    else $error("no startup load after reset");
  a_bpl_forced:
    assert property (!HAS_BACKPLANE_EXPORT |->
      !settings.backplane_clock_export)
    else $error("backplane export set on variant without it");
endmodule : rfc_regs_sva

// >>> rfc_host_model.sv
// Purpose: host controller issuing register write commands
// Assumes: inputs change at the falling clock edge
// Notes:   every command waits for its one answer byte
`timescale 1ns/1ns
module rfc_host_model
  import rfc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output      logic       rx_valid,
  output      logic [7:0] rx_byte,
  output      logic       tx_take
);
  initial
  begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_take  = 1'b0;
  end

  // address, then n payload bytes msb first, then one answer read
  task automatic send(input logic [7:0] a, input logic [39:0] pl,
                      input int n, output logic [7:0] ack);
    for (int k = 0; k <= n; k++)
    begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_byte  = (k == 0) ? a : pl[8*(n-k) +: 8];
      for (int i = 0; i < 200 && !rx_ready; i++) @(negedge mclk);
      @(posedge mclk);
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
    for (int i = 0; i < 200 && !tx_valid; i++) @(negedge mclk);
    tx_take = 1'b1;
    @(posedge mclk);
    ack     = tx_byte;
    @(negedge mclk);
    tx_take = 1'b0;
  endtask : send
endmodule : rfc_host_model

// >>> rfc_regs_tb.sv
// Purpose: self-checking bench of the rf configuration registers
// Assumes: host model drives the byte link, bench plays the store
// Notes:   expected settings kept in exp_cfg and compared whole
`timescale 1ns/1ns
module rfc_regs_tb;
  import rfc_pkg::*;
  logic          mclk, rst, rx_valid, rx_ready, tx_valid, tx_take;
  logic          freq_changed, nv_save_req, nv_load_req;
  logic          nv_save_done, nv_load_valid;
  logic [7:0]    rx_byte, tx_byte;
  rfc_gain_req_t gain_req;
  rfc_cfg_t      settings, nv_load_cfg, exp_cfg, saved_cfg;
  int            error_cnt, compares, save_cnt;

  rfc_regs #(.HAS_BACKPLANE_EXPORT(1'b0)) rfc_regs_i (
    .mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_take(tx_take), .freq_changed(freq_changed), .gain_req(gain_req),
    .settings(settings), .nv_save_req(nv_save_req),
    .nv_load_req(nv_load_req), .nv_save_done(nv_save_done),
    .nv_load_valid(nv_load_valid), .nv_load_cfg(nv_load_cfg));
  rfc_host_model rfc_host_model_i (
    .mclk(mclk), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_take(tx_take));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****************************************************************
  // nonvolatile store stand-in
  // ****************************************************************
  always @(negedge mclk)
  begin
    nv_load_valid <= nv_load_req;
    nv_save_done  <= (save_cnt == 1);
    saved_cfg     <= nv_save_req ? settings : saved_cfg;
    save_cnt      <= nv_save_req ? 4 : (save_cnt != 0 ? save_cnt - 1 : 0);
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [39:0] pl,
                    input int n, input logic [7:0] ea);
    logic [7:0] ack;
    rfc_host_model_i.send(a, pl, n, ack);
    chk("answer", ack, ea);
  endtask : wr

  // one-cycle step; returns while the gain request stands
  task automatic step;
    @(negedge mclk);
    freq_changed = 1'b1;
    @(negedge mclk);
    freq_changed = 1'b0;
  endtask : step

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_startup;
    for (int i = 0; i < 100 && !rx_ready; i++) @(negedge mclk);
    chk("startup", settings, exp_cfg);
  endtask : t_startup

  task automatic t_gain;
    wr(ADDR_AUTO_GAIN, 40'h00_1405_8a1f, 5, ACK_OK);
    exp_cfg.gain_track_on            = 1'b1;
    exp_cfg.amp_follow_computation   = 1'b1;
    exp_cfg.noise_linearity_tradeoff = 2'h3;
    exp_cfg.expected_input_db        = 8'h8a;
    exp_cfg.expected_mixer_db        = 8'h05;
    exp_cfg.expected_output_db       = 8'h14;
    chk("gain cfg", settings, exp_cfg);
    step();
    chk("gain valid", gain_req.valid, 1);
    chk("gain qdb", gain_req.gain_qdb, 120);
    chk("mixer qdb", gain_req.mixer_qdb, 60);
    chk("amp allowed", gain_req.amp_allowed, 1);
    chk("tradeoff", gain_req.tradeoff, 3);
    @(negedge mclk);
    chk("gain pulse", gain_req.valid, 0);
    wr(ADDR_AUTO_GAIN, 40'h00_7f7f_7f08, 5, ACK_OK);
    exp_cfg.gain_track_on            = 1'b0;
    exp_cfg.amp_follow_computation   = 1'b0;
    exp_cfg.noise_linearity_tradeoff = 2'h1;
    chk("levels kept", settings, exp_cfg);
    step();
    chk("no tracking", gain_req.valid, 0);
    wr(ADDR_AUTO_GAIN, 40'h00_0000_0009, 5, ACK_OK);
    exp_cfg.gain_track_on = 1'b1;
    chk("amp held cfg", settings, exp_cfg);
    step();
    chk("amp held", gain_req.amp_allowed, 0);
    chk("tradeoff low", gain_req.tradeoff, 1);
    chk("levels qdb", gain_req.gain_qdb, 120);
  endtask : t_gain

  task automatic t_standby;
    for (int s = 1; s < 5; s++)
    begin
      wr(ADDR_STANDBY, {36'h0, s[2:0], 1'b1}, 1, ACK_OK);
      exp_cfg.section_standby[s] = 1'b1;
      chk("standby", settings, exp_cfg);
    end
    wr(ADDR_STANDBY, 40'h0b, 1, ACK_OK);
    chk("bad section", settings, exp_cfg);
    wr(ADDR_STANDBY, 40'h00, 1, ACK_OK);
    exp_cfg.section_standby = 5'h00;
    chk("all active", settings, exp_cfg);
    wr(ADDR_STANDBY, 40'h01, 1, ACK_OK);
    exp_cfg.section_standby = 5'h1f;
    chk("all standby", settings, exp_cfg);
  endtask : t_standby

  task automatic t_ref;
    wr(ADDR_REF_CLOCK, 40'h0f, 1, ACK_OK);
    exp_cfg.external_ref_lock   = 1'b1;
    exp_cfg.ref_port_drive      = 1'b1;
    exp_cfg.ref_out_rate_select = 1'b1;
    chk("ref set", settings, exp_cfg);
    wr(ADDR_REF_CLOCK, 40'h02, 1, ACK_OK);
    exp_cfg.external_ref_lock   = 1'b0;
    exp_cfg.ref_out_rate_select = 1'b0;
    chk("ref port", settings, exp_cfg);
  endtask : t_ref

  task automatic t_trim_route;
    wr(ADDR_REF_TRIM, 40'h00beef, 3, ACK_OK);
    exp_cfg.ref_trim_word = 16'hbeef;
    chk("trim", settings, exp_cfg);
    for (int r = 0; r < 2; r++)
    begin
      wr(ADDR_OSC_ROUTE, {39'h0, r[0]}, 1, ACK_OK);
      exp_cfg.first_osc_routing = r[0];
      chk("route", settings, exp_cfg);
    end
  endtask : t_trim_route

  task automatic t_save_unknown;
    wr(ADDR_SAVE, 40'h00, 1, ACK_OK);
    chk("saved", saved_cfg, exp_cfg);
    wr(8'h40, 40'h55, 1, ACK_UNKNOWN);
    chk("unknown", settings, exp_cfg);
  endtask : t_save_unknown

  // mid-run reset; store hands back what was saved
  task automatic t_reboot;
    nv_load_cfg = saved_cfg;
    @(negedge mclk);
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    chk("reset cfg", settings, CFG_RESET);
    rst = 1'b0;
    t_startup();
  endtask : t_reboot

  initial
  begin
    rst          = 1'b1;
    freq_changed = 1'b0;
    error_cnt    = 0;
    compares     = 0;
    save_cnt     = 0;
    nv_load_cfg  = '0;
    nv_load_cfg.ref_trim_word          = 16'h1234;
    nv_load_cfg.backplane_clock_export = 1'b1;
    nv_load_cfg.first_osc_routing      = 1'b1;
    exp_cfg = nv_load_cfg;
    exp_cfg.backplane_clock_export = 1'b0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    t_startup();
    t_gain();
    t_standby();
    t_ref();
    t_trim_route();
    t_save_unknown();
    t_reboot();
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : rfc_regs_tb

bind rfc_regs rfc_regs_sva #(.HAS_BACKPLANE_EXPORT(HAS_BACKPLANE_EXPORT))
  rfc_regs_sva_i (
  .mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_take(tx_take), .freq_changed(freq_changed), .gain_req(gain_req),
  .settings(settings), .nv_save_req(nv_save_req),
  .nv_load_req(nv_load_req), .nv_save_done(nv_save_done),
  .nv_load_valid(nv_load_valid), .nv_load_cfg(nv_load_cfg));
